// *** verilog/fps_pkg.sv ***
package fps_pkg;

  localparam int CLK_NS = 4;
  localparam int DLY_W = 16;
  localparam int TMO_W = 40;

  ////////////////////////////////////////////////////////////////////////////
  // register map, one aligned word each
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;

  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_CLS_LSB = 4;
  localparam int CTRL_ALG = 7;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RES_LSB = 1;
  localparam int STAT_PDOWN = 4;

  // status bits of the polled byte
  localparam int DATA_POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_LIMIT_FLAG = 5;
  localparam int BUFFER_ABORT_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    OP_WRITE = 3'b000,
    OP_READ = 3'b001,
    OP_POLL_DATA = 3'b010,
    OP_POLL_TOGGLE = 3'b011,
    OP_RESTART = 3'b100,
    OP_PD_ENTER = 3'b101,
    OP_PD_EXIT = 3'b110
  } fps_op_t;

  typedef enum logic [2:0] {
    RES_NONE = 3'b000,
    RES_PASS = 3'b001,
    RES_FAIL = 3'b010,
    RES_ABORT = 3'b011,
    RES_TIMEOUT = 3'b100,
    RES_BADOP = 3'b101
  } fps_res_t;

  localparam logic [2:0] CLS_WORD = 3'h0;
  localparam logic [2:0] CLS_BUFFER = 3'h1;
  localparam logic [2:0] CLS_SECTOR = 3'h2;
  localparam logic [2:0] CLS_CHIP_ERASE = 3'h3;
  localparam logic [2:0] CLS_CHIP_PROG = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // pin timing, least times rounded up
  localparam int WR_PULSE_NS = 35;
  localparam int WR_HIGH_NS = 30;
  localparam int RD_ACCESS_NS = 100;
  localparam int RD_GAP_NS = 35;
  localparam int SYNC_CYC = 2;
  localparam int RP_BUSY_NS = 10_000;
  localparam int RP_IDLE_NS = 500;
  localparam int RH_NS = 200;
  localparam int READY_BUSY_NS = 20_000;
  localparam int READY_IDLE_NS = 500;
  localparam int PD_ENTRY_NS = 20_000;
  localparam int PD_EXIT_NS = 200_000;

  localparam logic [DLY_W-1:0] WR_PULSE_CYC = DLY_W'((WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] WR_HIGH_CYC = DLY_W'((WR_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] RD_ACCESS_CYC = DLY_W'((RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1);
  localparam logic [DLY_W-1:0] RD_GAP_CYC = DLY_W'((RD_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] RP_BUSY_CYC = DLY_W'((RP_BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] RP_IDLE_CYC = DLY_W'((RP_IDLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] RH_CYC = DLY_W'((RH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] READY_IDLE_CYC = DLY_W'((READY_IDLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DLY_W-1:0] READY_BUSY_CYC = DLY_W'(READY_BUSY_NS / CLK_NS);
  localparam logic [DLY_W-1:0] PD_ENTRY_CYC = DLY_W'(PD_ENTRY_NS / CLK_NS);
  localparam logic [DLY_W-1:0] PD_EXIT_CYC = DLY_W'(PD_EXIT_NS / CLK_NS);

  ////////////////////////////////////////////////////////////////////////////
  // operation limits, longest times rounded down
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint WORD_PROG_MAX_NS = 360_000;
  localparam longint WORD_PROG_TYP_NS = 11_000;
  localparam longint SECTOR_ERASE_MAX_S = 5;
  localparam longint CHIP_ERASE_MAX_S = 300;
  localparam longint CHIP_PROG_MAX_S = 350;
  localparam longint SECTOR_WORDS = 65536;
  localparam longint SECTORS = 256;
  localparam longint BUFFER_WORDS = 32;

  // zero pass before erase is outside the quoted figures, so budget it apart
  localparam longint PREPROG_SECTOR_CYC = SECTOR_WORDS * WORD_PROG_TYP_NS / CLK_NS;
  localparam logic [TMO_W-1:0] TMO_WORD_CYC = TMO_W'(WORD_PROG_MAX_NS / CLK_NS);
  localparam logic [TMO_W-1:0] TMO_BUFFER_CYC = TMO_W'(BUFFER_WORDS * WORD_PROG_MAX_NS / CLK_NS);
  localparam logic [TMO_W-1:0] TMO_SECTOR_CYC =
    TMO_W'(SECTOR_ERASE_MAX_S * NS_PER_S / CLK_NS + PREPROG_SECTOR_CYC);
  localparam logic [TMO_W-1:0] TMO_CHIP_ERASE_CYC =
    TMO_W'(CHIP_ERASE_MAX_S * NS_PER_S / CLK_NS + SECTORS * PREPROG_SECTOR_CYC);
  localparam logic [TMO_W-1:0] TMO_CHIP_PROG_CYC = TMO_W'(CHIP_PROG_MAX_S * NS_PER_S / CLK_NS);

endpackage : fps_pkg

// *** verilog/fps_tmr.sv ***
`timescale 1ns/1ps
`default_nettype none

module fps_tmr #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  // state
  output logic done
);

  typedef struct packed {
    logic [W-1:0] count;
  } fps_tmr_regs_t;

  fps_tmr_regs_t s;
  fps_tmr_regs_t next_s;

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.count = value;
    end else if (s.count != '0) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = (s.count == '0);

endmodule : fps_tmr

`default_nettype wire

// *** verilog/fps_host.sv ***
// Function
// - data poll passes once data_poll_bit equals written data bit.
// - on fail_limit_flag with mismatch, read again; fail only if still mismatched.
// - buffered write only: buffer_abort_bit with mismatch, recheck, then report abort.
// - poll at programmed address, or inside the erased sector.
// - toggle method reads status twice and compares the toggle bit.
// - fail_limit_flag during toggling forces a second toggle check before failing.
// - restart_n low 10 us if algorithm busy, else 500 ns.
// - restart_n high at least 200 ns before any read.
// - erase budget adds the zero-programming pass outside quoted figures.
`timescale 1ns/1ps
`default_nettype none

module fps_host import fps_pkg::*; #(
  parameter logic [DLY_W-1:0] READY_BUSY_P = READY_BUSY_CYC,
  parameter logic [DLY_W-1:0] PD_ENTRY_P = PD_ENTRY_CYC,
  parameter logic [DLY_W-1:0] PD_EXIT_P = PD_EXIT_CYC,
  parameter logic [TMO_W-1:0] TMO_WORD_P = TMO_WORD_CYC,
  parameter logic [TMO_W-1:0] TMO_BUFFER_P = TMO_BUFFER_CYC,
  parameter logic [TMO_W-1:0] TMO_SECTOR_P = TMO_SECTOR_CYC,
  parameter logic [TMO_W-1:0] TMO_CHIP_ERASE_P = TMO_CHIP_ERASE_CYC,
  parameter logic [TMO_W-1:0] TMO_CHIP_PROG_P = TMO_CHIP_PROG_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // flash pins
  output logic [23:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic write_strobe_n,
  output logic restart_n
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_LOW = 3'b001,
    ST_WR_HIGH = 3'b010,
    ST_RD_LOW = 3'b011,
    ST_RD_HIGH = 3'b100,
    ST_EVAL = 3'b101,
    ST_RST_LOW = 3'b110,
    ST_WAIT = 3'b111
  } fps_state_t;

  typedef struct packed {
    fps_state_t st;
    fps_op_t op;
    logic [2:0] cls;
    logic alg_busy;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] prev;
    logic [1:0] stage;
    logic busy;
    fps_res_t res;
    logic pdown;
    logic [15:0] dq_meta;
    logic [15:0] dq_sync;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [23:0] pin_addr;
    logic [15:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
  } fps_regs_t;

  localparam fps_regs_t RESET_S = '{st: ST_IDLE, op: OP_WRITE, res: RES_NONE, ce_n: 1'b1, oe_n: 1'b1,
                                    we_n: 1'b1, rst_n: 1'b1, default: '0};
  // recovery after the pulse also covers the high time before a read
  localparam logic [DLY_W-1:0] REC_BUSY_CYC =
    (READY_BUSY_P > RP_BUSY_CYC + RH_CYC) ? DLY_W'(READY_BUSY_P - RP_BUSY_CYC) : RH_CYC;
  localparam logic [DLY_W-1:0] REC_IDLE_CYC =
    (READY_IDLE_CYC > RP_IDLE_CYC + RH_CYC) ? DLY_W'(READY_IDLE_CYC - RP_IDLE_CYC) : RH_CYC;

  fps_regs_t s;
  fps_regs_t n;
  logic dly_load;
  logic [DLY_W-1:0] dly_val;
  logic dly_done;
  logic tmo_load;
  logic [TMO_W-1:0] tmo_val;
  logic tmo_done;
  logic setup;
  logic wr;
  logic go;
  logic again;
  logic toggling;
  logic poll_ok;
  fps_res_t fin;

  fps_tmr #(.W(DLY_W)) u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .load(dly_load),
    .value(dly_val),
    .done(dly_done)
  );

  fps_tmr #(.W(TMO_W)) u_tmo (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmo_load),
    .value(tmo_val),
    .done(tmo_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    dly_load = 1'b0;
    dly_val = '0;
    tmo_load = 1'b0;
    tmo_val = '0;
    again = 1'b0;
    fin = RES_NONE;
    toggling = s.rdata[TOGGLE_BIT] ^ s.prev[TOGGLE_BIT];
    poll_ok = (s.rdata[DATA_POLL_BIT] == s.wdata[DATA_POLL_BIT]);
    n.dq_meta = flash_dq_in;
    n.dq_sync = s.dq_meta;

    // apb: zero wait states, answer registered in the setup cycle
    setup = psel & ~penable;
    wr = psel & penable & s.pready & pwrite & ~s.pslverr;
    n.pready = setup;
    n.pslverr = 1'b0;
    n.prdata = '0;
    if (setup) begin
      case (paddr)
        REG_CTRL: n.prdata = {24'h000000, s.alg_busy, s.cls, s.op, 1'b0};
        REG_ADDR: n.prdata = {8'h00, s.addr};
        REG_WDATA: n.prdata = {16'h0000, s.wdata};
        REG_STATUS: n.prdata = {27'h0000000, s.pdown, s.res, s.busy};
        REG_RDATA: n.prdata = {16'h0000, s.rdata};
        default: n.pslverr = 1'b1;
      endcase
      if (pwrite) begin
        n.prdata = '0;
      end
    end
    // operands are frozen while an operation runs
    if (wr && !s.busy && paddr == REG_ADDR) begin
      n.addr = pwdata[23:0];
    end
    if (wr && !s.busy && paddr == REG_WDATA) begin
      n.wdata = pwdata[15:0];
    end
    go = wr && !s.busy && paddr == REG_CTRL;
    if (go) begin
      n.op = fps_op_t'(pwdata[CTRL_OP_LSB +: 3]);
      n.cls = pwdata[CTRL_CLS_LSB +: 3];
      n.alg_busy = pwdata[CTRL_ALG];
    end
    go = go && pwdata[CTRL_START];

    ////////////////////////////////////////////////////////////////////////////
    unique case (s.st)
      ST_IDLE: begin
        if (go) begin
          n.busy = 1'b1;
          n.res = RES_NONE;
          n.stage = 2'd0;
          n.pin_addr = n.addr;
          if (s.pdown && n.op != OP_PD_EXIT && n.op != OP_RESTART) begin
            n.busy = 1'b0;
            n.res = RES_BADOP;
          end else begin
            unique case (n.op)
              OP_WRITE, OP_PD_ENTER, OP_PD_EXIT: begin
                n.st = ST_WR_LOW;
                n.ce_n = 1'b0;
                n.we_n = 1'b0;
                n.dq_oe = 1'b1;
                n.dq_out = n.wdata;
                dly_load = 1'b1;
                dly_val = WR_PULSE_CYC;
              end
              OP_READ, OP_POLL_DATA, OP_POLL_TOGGLE: begin
                again = 1'b1;
                tmo_load = 1'b1;
                case (n.cls)
                  CLS_BUFFER: tmo_val = TMO_BUFFER_P;
                  CLS_SECTOR: tmo_val = TMO_SECTOR_P;
                  CLS_CHIP_ERASE: tmo_val = TMO_CHIP_ERASE_P;
                  CLS_CHIP_PROG: tmo_val = TMO_CHIP_PROG_P;
                  default: tmo_val = TMO_WORD_P;
                endcase
              end
              OP_RESTART: begin
                n.st = ST_RST_LOW;
                n.rst_n = 1'b0;
                dly_load = 1'b1;
                dly_val = n.alg_busy ? RP_BUSY_CYC : RP_IDLE_CYC;
              end
              default: begin
                n.busy = 1'b0;
                n.res = RES_BADOP;
              end
            endcase
          end
        end
      end
      ST_WR_LOW: begin
        if (dly_done) begin
          n.st = ST_WR_HIGH;
          n.we_n = 1'b1;
          n.ce_n = 1'b1;
          dly_load = 1'b1;
          dly_val = WR_HIGH_CYC;
        end
      end
      ST_WR_HIGH: begin
        if (dly_done) begin
          n.dq_oe = 1'b0;
          if (s.op == OP_PD_ENTER || s.op == OP_PD_EXIT) begin
            n.st = ST_WAIT;
            dly_load = 1'b1;
            dly_val = (s.op == OP_PD_ENTER) ? PD_ENTRY_P : PD_EXIT_P;
          end else begin
            n.st = ST_IDLE;
            n.busy = 1'b0;
            n.res = RES_PASS;
          end
        end
      end
      ST_RD_LOW: begin
        if (dly_done) begin
          n.prev = s.rdata;
          n.rdata = s.dq_sync;
          n.st = ST_RD_HIGH;
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          dly_load = 1'b1;
          dly_val = RD_GAP_CYC;
        end
      end
      ST_RD_HIGH: begin
        if (dly_done) begin
          if (s.op == OP_READ) begin
            n.st = ST_IDLE;
            n.busy = 1'b0;
            n.res = RES_PASS;
          end else begin
            n.st = ST_EVAL;
          end
        end
      end
      ST_EVAL: begin
        if (s.op == OP_POLL_DATA) begin
          if (poll_ok) begin
            fin = RES_PASS;
          end else if (s.stage == 2'd1) begin
            fin = RES_FAIL;
          end else if (s.stage == 2'd2) begin
            fin = RES_ABORT;
          end else if (s.cls == CLS_BUFFER && s.rdata[BUFFER_ABORT_BIT]) begin
            again = 1'b1;
            n.stage = 2'd2;
          end else if (s.rdata[FAIL_LIMIT_FLAG]) begin
            again = 1'b1;
            n.stage = 2'd1;
          end else if (tmo_done) begin
            fin = RES_TIMEOUT;
          end else begin
            again = 1'b1;
          end
        end else begin
          unique case (s.stage)
            2'd0: begin
              again = 1'b1;
              n.stage = 2'd1;
            end
            2'd1: begin
              if (!toggling) begin
                fin = RES_PASS;
              end else if (s.rdata[FAIL_LIMIT_FLAG]) begin
                again = 1'b1;
                n.stage = 2'd2;
              end else if (tmo_done) begin
                fin = RES_TIMEOUT;
              end else begin
                again = 1'b1;
                n.stage = 2'd0;
              end
            end
            2'd2: begin
              again = 1'b1;
              n.stage = 2'd3;
            end
            2'd3: fin = toggling ? RES_FAIL : RES_PASS;
          endcase
        end
        if (!again) begin
          n.st = ST_IDLE;
          n.busy = 1'b0;
          n.res = fin;
        end
      end
      ST_RST_LOW: begin
        if (dly_done) begin
          n.st = ST_WAIT;
          n.rst_n = 1'b1;
          dly_load = 1'b1;
          dly_val = s.alg_busy ? REC_BUSY_CYC : REC_IDLE_CYC;
        end
      end
      ST_WAIT: begin
        if (dly_done) begin
          n.st = ST_IDLE;
          n.busy = 1'b0;
          n.res = RES_PASS;
          if (s.op == OP_PD_ENTER) begin
            n.pdown = 1'b1;
          end else if (s.op == OP_PD_EXIT) begin
            n.pdown = 1'b0;
          end
        end
      end
    endcase

    // common read launch, polling always at the operand address
    if (again) begin
      n.st = ST_RD_LOW;
      n.ce_n = 1'b0;
      n.oe_n = 1'b0;
      n.dq_oe = 1'b0;
      dly_load = 1'b1;
      dly_val = RD_ACCESS_CYC;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RESET_S;
    end else begin
      s <= n;
    end
  end

  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign flash_addr = s.pin_addr;
  assign flash_dq_out = s.dq_out;
  assign flash_dq_oe = s.dq_oe;
  assign flash_ce_n = s.ce_n;
  assign flash_oe_n = s.oe_n;
  assign write_strobe_n = s.we_n;
  assign restart_n = s.rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks; helper counters of restart pin low and high time
  logic [DLY_W-1:0] low_cnt;
  logic [DLY_W-1:0] high_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= '0;
      high_cnt <= '1;
    end else begin
      low_cnt <= s.rst_n ? '0 : DLY_W'(low_cnt + 1'b1);
      high_cnt <= !s.rst_n ? '0 : ((high_cnt == '1) ? high_cnt : DLY_W'(high_cnt + 1'b1));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_eval_data;
    s.st == ST_EVAL && s.op == OP_POLL_DATA;
  endsequence

  sequence s_second_read;
    s.st == ST_RD_LOW && s.stage == 2'd1;
  endsequence

  property p_data_pass;
    s_eval_data and (s.rdata[DATA_POLL_BIT] == s.wdata[DATA_POLL_BIT]) |=> s.res == RES_PASS && !s.busy;
  endproperty
  a_data_pass: assert property (p_data_pass) else $error("data poll match not reported as pass");

  property p_fail_recheck;
    s_eval_data and (s.stage == 2'd0 && !poll_ok && s.rdata[FAIL_LIMIT_FLAG]
      && !(s.cls == CLS_BUFFER && s.rdata[BUFFER_ABORT_BIT])) |=> s_second_read ##0 s.res != RES_FAIL;
  endproperty
  a_fail_recheck: assert property (p_fail_recheck) else $error("fail flag did not cause a recheck read");

  property p_abort_only_buffer;
    $rose(s.res == RES_ABORT) |-> s.cls == CLS_BUFFER && $past(s.stage) == 2'd2;
  endproperty
  a_abort_only_buffer: assert property (p_abort_only_buffer) else $error("abort reported outside buffered write");

  property p_poll_addr;
    !s.ce_n && (s.op == OP_POLL_DATA || s.op == OP_POLL_TOGGLE) |-> flash_addr == s.addr;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("poll read at wrong address");

  property p_toggle_pair;
    s.st == ST_EVAL && s.op == OP_POLL_TOGGLE && s.stage == 2'd0 |=> s_second_read ##1 !flash_oe_n;
  endproperty
  a_toggle_pair: assert property (p_toggle_pair) else $error("toggle check lacks a second read");

  property p_toggle_fail;
    $rose(s.res == RES_FAIL) && s.op == OP_POLL_TOGGLE |-> s.stage == 2'd3;
  endproperty
  a_toggle_fail: assert property (p_toggle_fail) else $error("toggle failure without recheck");

  property p_restart_width;
    $rose(restart_n) |-> low_cnt >= (s.alg_busy ? RP_BUSY_CYC : RP_IDLE_CYC);
  endproperty
  a_restart_width: assert property (p_restart_width) else $error("restart pulse too short");

  property p_restart_high;
    $fell(flash_oe_n) |-> high_cnt >= RH_CYC;
  endproperty
  a_restart_high: assert property (p_restart_high) else $error("read too soon after restart release");

  property p_timeout;
    s_eval_data and (s.stage == 2'd0 && !poll_ok && !s.rdata[FAIL_LIMIT_FLAG]
      && !(s.cls == CLS_BUFFER && s.rdata[BUFFER_ABORT_BIT]) && tmo_done) |=> s.res == RES_TIMEOUT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("expired poll not ended by timeout");

  property p_pd_exit_quiet;
    $rose(s.st == ST_WAIT && s.op == OP_PD_EXIT) |-> (flash_ce_n && s.busy)[*8];
  endproperty
  a_pd_exit_quiet: assert property (p_pd_exit_quiet) else $error("access during power-down release");

endmodule : fps_host

`default_nettype wire

// *** verif/fps_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module fps_flash_model import fps_pkg::*; (
  // flash pins
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic write_strobe_n,
  input wire logic restart_n,
  output logic [15:0] flash_dq_in,
  // scenario control: 1 raises fail flag, 2 raises abort bit
  input wire logic [1:0] mode,
  input wire logic [7:0] busy_reads
);
  logic [15:0] mem = 16'h0000;
  logic [23:0] last_addr = 24'h000000;
  logic [7:0] left = 8'h00;
  logic tgl = 1'b0;

  // one process owns all model state; the short wait lets pins that move together settle
  // busy length counted in status reads, not time, to keep runs short
  initial begin
    flash_dq_in = 16'hFFFF;
    forever begin
      @(posedge write_strobe_n or negedge restart_n or negedge flash_oe_n or posedge flash_oe_n);
      #1;
      if (restart_n === 1'b0) begin
        left = 8'h00;
      end else if (flash_dq_oe === 1'b1) begin
        mem = flash_dq_out;
        last_addr = flash_addr;
        // operation starts at once, well inside the sector append window
        left = busy_reads;
      end else if (flash_oe_n === 1'b0) begin
        tgl = ~tgl;
        // a wrong polling address never completes
        if (flash_ce_n === 1'b0 && left == 8'h00 && flash_addr == last_addr) begin
          flash_dq_in = mem;
        end else begin
          flash_dq_in = {8'h00, ~mem[7], tgl, mode == 2'h1, 3'h0, mode == 2'h2, 1'b0};
          if (left != 8'h00) begin
            left = left - 8'h01;
          end
        end
      end else begin
        // released bus shows the inverse, never a stale value
        flash_dq_in = ~flash_dq_in;
      end
    end
  end
endmodule : fps_flash_model

`default_nettype wire

// *** verif/tb_fps_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_fps_host import fps_pkg::*; ;
  typedef struct packed {
    logic [2:0] op;
    logic [2:0] cls;
    logic [1:0] md;
    logic [7:0] br;
    logic [2:0] res;
  } fps_tb_case_t;
  localparam fps_tb_case_t CASES [9] = '{
    '{OP_POLL_DATA, CLS_WORD, 2'h0, 8'h03, RES_PASS}, '{OP_POLL_DATA, CLS_WORD, 2'h1, 8'h01, RES_PASS},
    '{OP_POLL_DATA, CLS_WORD, 2'h1, 8'hC8, RES_FAIL}, '{OP_POLL_DATA, CLS_BUFFER, 2'h2, 8'h01, RES_PASS},
    '{OP_POLL_DATA, CLS_BUFFER, 2'h2, 8'hC8, RES_ABORT}, '{OP_POLL_DATA, CLS_WORD, 2'h2, 8'hC8, RES_TIMEOUT},
    '{OP_POLL_TOGGLE, CLS_WORD, 2'h0, 8'h03, RES_PASS}, '{OP_POLL_TOGGLE, CLS_WORD, 2'h1, 8'hC8, RES_FAIL},
    '{OP_POLL_DATA, CLS_SECTOR, 2'h0, 8'hFF, RES_TIMEOUT}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, dq_oe, ce_n, oe_n, ws_n, rs_n;
  logic [31:0] prdata, d, a, q;
  logic [23:0] faddr;
  logic [15:0] dq_out, dq_in;
  logic [1:0] mode = 2'h0;
  logic [7:0] busy_reads = 8'h00;
  logic chk = 1'b0;
  logic perr;
  logic [DLY_W-1:0] low_cnt = '0;
  logic [DLY_W-1:0] low_len = '0;
  logic [31:0] expq [$];
  integer seed = 32'h609ee17a;
  int err_count = 0;
  int cmp_count = 0;

  always #2 pclk = ~pclk;

  // buffer and chip limits keep their defaults: no scenario lets them run out
  fps_host #(.READY_BUSY_P(16'hA28), .PD_ENTRY_P(16'h14), .PD_EXIT_P(16'h14), .TMO_WORD_P(40'h7D0),
    .TMO_SECTOR_P(40'h7D0)
  ) i_fps_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .write_strobe_n(ws_n), .restart_n(rs_n));

  fps_flash_model i_fps_flash_model (.flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .write_strobe_n(ws_n), .restart_n(rs_n), .flash_dq_in(dq_in),
    .mode(mode), .busy_reads(busy_reads));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_read(input logic [7:0] ad, input logic [31:0] e);
    expq.push_back(e);
    chk <= 1'b1;
    apb(1'b0, ad, 32'h0, q);
    chk <= 1'b0;
  endtask : chk_read

  task automatic run(input logic [2:0] op, input logic [2:0] cls, input logic alg, input logic [31:0] e);
    apb(1'b1, REG_CTRL, {24'h0, alg, cls, op, 1'b1}, q);
    do begin
      apb(1'b0, REG_STATUS, 32'h0, q);
    end while (q[STAT_BUSY] !== 1'b0);
    chk_read(REG_STATUS, e);
  endtask : run

  task automatic setup_op;
    d = $random(seed);
    a = $random(seed);
    apb(1'b1, REG_ADDR, {8'h0, a[23:0]}, q);
    apb(1'b1, REG_WDATA, {16'h0, d[15:0]}, q);
  endtask : setup_op

  task automatic tally_and_finish;
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // results are announced by a flagged status or read-data register read and matched in order
  always @(posedge pclk) begin
    if (chk && psel && penable && pready === 1'b1 && !pwrite) begin
      cmp_count++;
      if (prdata !== expq[0]) begin
        err_count++;
        $display("unexpected prdata exp %h got %h", expq[0], prdata);
      end
      void'(expq.pop_front());
    end
  end

  always @(posedge pclk) begin
    if (rs_n === 1'b0) begin
      low_cnt <= low_cnt + 1'b1;
    end else if (low_cnt != '0) begin
      low_len <= low_cnt;
      low_cnt <= '0;
    end
  end

  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    setup_op;
    run(OP_WRITE, CLS_WORD, 1'b0, 32'h2);
    run(OP_READ, CLS_WORD, 1'b0, 32'h2);
    chk_read(REG_RDATA, {16'h0, d[15:0]});
    foreach (CASES[i]) begin
      mode <= CASES[i].md;
      busy_reads <= CASES[i].br;
      setup_op;
      run(OP_WRITE, CASES[i].cls, 1'b0, 32'h2);
      run(CASES[i].op, CASES[i].cls, 1'b0, {28'h0, CASES[i].res, 1'b0});
    end
    mode <= 2'h0;
    setup_op;
    run(OP_WRITE, CLS_WORD, 1'b0, 32'h2);
    run(OP_RESTART, CLS_WORD, 1'b1, 32'h2);
    // pulse also spans the cycle in which the width timer shows done
    chk_val("restart_low", 32'(RP_BUSY_CYC) + 32'h1, 32'(low_len));
    run(OP_POLL_DATA, CLS_WORD, 1'b0, 32'h2);
    run(OP_RESTART, CLS_WORD, 1'b0, 32'h2);
    chk_val("restart_low", 32'(RP_IDLE_CYC) + 32'h1, 32'(low_len));
    busy_reads <= 8'h00;
    run(OP_PD_ENTER, CLS_WORD, 1'b0, 32'h12);
    run(OP_WRITE, CLS_WORD, 1'b0, 32'h1A);
    run(OP_PD_EXIT, CLS_WORD, 1'b0, 32'h2);
    run(3'h7, CLS_WORD, 1'b0, 32'hA);
    apb(1'b0, 8'h14, 32'h0, q);
    chk_val("pslverr", 32'h1, {31'h0, perr});
    tally_and_finish;
  end
endmodule : tb_fps_host

`default_nettype wire
